/* hdl/ftic_blink.sv */
/*
 indicator pattern generator: rise, hold, fall, dark per period,
 active periods then silent blank periods, or steady light.
 assumes a one-cycle millisecond tick from the parent.
*/
`timescale 1ns/100ps
`include "ftic_consts.svh"

module ftic_blink
    import ftic_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // control
    input  wire logic        ms_tick,
    input  wire logic        enable,
    input  wire logic        blink,
    input  wire logic [2:0]  period_n,
    input  wire logic [1:0]  ramp_sel,
    input  wire logic [3:0]  pulse_sel,
    input  wire logic [3:0]  blank_n,
    // pattern
    output ftic_phase_e      phase,
    output logic             lit
);

    logic [9:0] ms_cnt;
    logic [9:0] len;
    logic [7:0] per_cnt;
    logic [7:0] total;
    logic [3:0] active;
    logic       done;

    function automatic logic [9:0] ramp_ms(input logic [1:0] sel);
        case (sel)
            2'h0:    ramp_ms = `FTIC_RAMP0_MS;
            2'h1:    ramp_ms = `FTIC_RAMP1_MS;
            2'h2:    ramp_ms = `FTIC_RAMP2_MS;
            default: ramp_ms = `FTIC_RAMP3_MS;
        endcase
    endfunction

    // phase length; blank is replayed periods with the source dark
    // period and blank lengths
    assign active = {1'b0, period_n} + 4'h1;
    assign total  = 8'(active * ({1'b0, blank_n} + 5'h01));
    assign len    = (phase == FTIC_RISE || phase == FTIC_FALL) ?
                    ramp_ms(ramp_sel) : 10'(pulse_sel * `FTIC_STEP_MS);
    assign done   = (len == 10'h000) || (ms_tick && (ms_cnt + 10'h001 >= len));
    assign lit    = (phase != FTIC_IDLE) && (!blink || per_cnt < 8'(active));

    // pattern sequencer; disabling always restarts from the top
    // restart on enable
    always_ff @(posedge core_clk)
    begin
        if (srst || !enable)
        begin
            phase   <= FTIC_IDLE;
            ms_cnt  <= 10'h000;
            per_cnt <= 8'h00;
        end
        else if (!blink)
        begin
            phase   <= FTIC_HOLD;
            ms_cnt  <= 10'h000;
            per_cnt <= 8'h00;
        end
        else if (phase == FTIC_IDLE)
            phase <= FTIC_RISE;
        else if (done)
        begin
            ms_cnt <= 10'h000;
            case (phase)
                FTIC_RISE: phase <= FTIC_HOLD;
                FTIC_HOLD: phase <= FTIC_FALL;
                FTIC_FALL: phase <= FTIC_LOW;
                FTIC_LOW:
                begin
                    phase   <= FTIC_RISE;
                    per_cnt <= (per_cnt + 8'h01 >= total) ? 8'h00 : per_cnt + 8'h01;
                end
                default:   phase <= FTIC_IDLE;
            endcase
        end
        else if (ms_tick)
            ms_cnt <= ms_cnt + 10'h001;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    restart_idle_a: assert property (!enable |=> phase == FTIC_IDLE)
        else $error("indicator did not restart");
    blank_dark_a: assert property (blink && per_cnt >= 8'(active) |-> !lit)
        else $error("indicator lit during blank");

endmodule

/* hdl/ftic_consts.svh */
/*
 constants of the flash, torch and indicator control block:
 register offsets, bit positions, reset values and timing figures.
 assumes a 200 mhz core clock and one byte wide register port.
*/
`ifndef FTIC_CONSTS_SVH
`define FTIC_CONSTS_SVH

// register offsets
`define FTIC_A_EN       8'h10
`define FTIC_A_IND      8'h12
`define FTIC_A_BLINK    8'h13
`define FTIC_A_VINMON   8'h80
`define FTIC_A_TORCH    8'ha0
`define FTIC_A_FLASH    8'hb0
`define FTIC_A_DUR      8'hc0
`define FTIC_A_FLAGS    8'hd0
`define FTIC_A_CFG1     8'he0
`define FTIC_A_CFG2     8'hf0

// enable register fields
`define FTIC_EN_MODE_HI 1
`define FTIC_EN_MODE_LO 0
`define FTIC_EN_SRCB    3
`define FTIC_EN_SRCA    4
`define FTIC_EN_STRB    5
`define FTIC_EN_IND     6
`define FTIC_EN_BLINK   7
`define FTIC_MODE_TORCH 2'h2
`define FTIC_MODE_FLASH 2'h3

// configuration fields
`define FTIC_C1_NTC     4
`define FTIC_C1_POL     5
`define FTIC_C1_HWT     7
`define FTIC_C2_VINSD   3
`define FTIC_C2_SYNCSD  4

// flag bits
`define FTIC_FL_TO      0
`define FTIC_FL_OVP     2
`define FTIC_FL_VIN     4
`define FTIC_FL_SYNC    6

// reset values
`define FTIC_RST_ZERO   8'h00
`define FTIC_RST_CFG1   8'h20

// timing
`define FTIC_CLK_NS     5
`define FTIC_MS_NS      1000000
`define FTIC_DEGL_NS    250000
`define FTIC_STEP_MS    32
`define FTIC_RAMP0_MS   10'h04e
`define FTIC_RAMP1_MS   10'h09c
`define FTIC_RAMP2_MS   10'h138
`define FTIC_RAMP3_MS   10'h270

`endif

/* hdl/ftic_core.sv */
/*
 control logic of a two-source led flash driver: flash, torch,
 sync pin handling, timeout, monitors and the indicator.
 assumes a byte register port fed by the serial interface engine,
 pins synchronous to core_clk, raw analogue comparator outputs.
*/
// Behaviour
// - config2 bit 4 set: active sync pin shuts sources down instead.
// - after sync shutdown, flash needs pin inactive and flags read.
// - sync shutdown acts on an active edge; rearmed by a flags read.
// - enable bits 4 and 3 switch source a and source b.
// - sources use torch or flash setting field for the current mode.
// - config1 bit 7 set: sync pin high requests torch current.
// - flash from pin or register beats torch requests, but not an active sync pin or a torch monitor event.
// - pin torch mode: flash end turns sources off, clears config1 bit 7.
// - overvoltage comparator stops both power switches until released.
// - duration bits 6:5 pick current limit; trip stops rest of cycle.
// - duration bits 4:0 set timeout, 32 ms steps, 32 to 1024 ms.
// - config1 bit 4 picks indicator source or thermistor input.
// - enable bit 6 lights the indicator, bit 7 selects blinking.
// - active periods then blank of active time times blank count.
// - indicator pulse width 0 to 480 ms in 32 ms steps.
// - indicator current has eight levels.
// - one ramp time for rise and fall: 78, 156, 312, 624 ms.
// - monitor bit 0 enables input monitor, bits 2:1 set threshold.
// - config2 bit 3 picks torch or shutdown on a monitor event.
// - monitor event ends after input recovers and flags are read.
// - monitor acts after 250 us continuous low, sets its flag.
// - config1 bit 7 clear: pin is sync input, bit 5 polarity.
// - reading flags clears them; a set bit means the event happened.
`timescale 1ns/100ps
`include "ftic_consts.svh"

module ftic_core
    import ftic_pkg::*;
#(
    parameter int MS_CYCLES   = `FTIC_MS_NS / `FTIC_CLK_NS,
    parameter int DEGL_CYCLES = `FTIC_DEGL_NS / `FTIC_CLK_NS
)(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // pins, low on hardware_shutdown_pin shuts down
    input  wire logic        hardware_shutdown_pin,
    input  wire logic        strobe_pin,
    input  wire logic        pa_sync_torch_pin,
    // analogue comparators
    input  wire logic        vin_below_cmp,
    input  wire logic        ovp_cmp,
    input  wire logic        ilim_cmp,
    input  wire logic        sw_cycle_start,
    // led sources
    output logic             source_a_on,
    output logic             source_b_on,
    output logic      [3:0]  source_a_code,
    output logic      [3:0]  source_b_code,
    output logic             flash_mode,
    // power stage
    output logic             power_sw_en,
    output logic      [1:0]  ilim_sel,
    output logic             input_monitor_en,
    output logic      [1:0]  input_monitor_threshold,
    // indicator pin
    output logic             thermistor_sel,
    output logic             indicator_on,
    output logic      [2:0]  indicator_current,
    output ftic_phase_e      indicator_phase
);

    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int DGW = $clog2(DEGL_CYCLES + 1);

    logic [7:0]     en, cfg1, cfg2, dur, vinmon, torch, flash, ind, blnk, flags;
    logic [7:0]     flag_set;
    logic [MSW-1:0] ms_div;
    logic           ms_tick;
    logic [1:0]     vin_m, ovp_m, ilim_m;
    logic           uv_s, ovp_s, ilim_s, ovp_prev, ilim_hold;
    logic [DGW-1:0] degl_cnt;
    logic           vin_trip, vin_evt;
    logic           sync_act, sync_prev, sync_edge, sync_shut, sync_armed;
    logic           raw_flash, flash_req, flash_prev, flash_end, to_done, to_hit;
    logic [10:0]    to_ms, to_lim;
    logic           force_off, force_torch, torch_req, flags_rd, ind_lit;
    ftic_mode_e     mode, next_mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign flags_rd = reg_rd && hit(reg_addr, `FTIC_A_FLAGS);

    // millisecond tick; too slow for a per-cycle count anywhere else
    // millisecond divider
    always_ff @(posedge core_clk)
    begin
        if (srst || ms_div == MSW'(MS_CYCLES - 1))
            ms_div <= '0;
        else
            ms_div <= ms_div + MSW'(1);
        ms_tick <= !srst && (ms_div == MSW'(MS_CYCLES - 1));
    end

    // two-stage synchronisers for the comparators
    // comparator synchronisers
    always_ff @(posedge core_clk)
    begin
        vin_m  <= {vin_m[0], vin_below_cmp};
        ovp_m  <= {ovp_m[0], ovp_cmp};
        ilim_m <= {ilim_m[0], ilim_cmp};
    end
    assign uv_s   = vin_m[1];
    assign ovp_s  = ovp_m[1];
    assign ilim_s = ilim_m[1];

    // register writes; hardware clears win over a same-cycle write
    always_ff @(posedge core_clk)
    begin
        if (srst || !hardware_shutdown_pin)
        begin
            en     <= `FTIC_RST_ZERO;
            cfg1   <= `FTIC_RST_CFG1;
            cfg2   <= `FTIC_RST_ZERO;
            dur    <= `FTIC_RST_ZERO;
            vinmon <= `FTIC_RST_ZERO;
            torch  <= `FTIC_RST_ZERO;
            flash  <= `FTIC_RST_ZERO;
            ind    <= `FTIC_RST_ZERO;
            blnk   <= `FTIC_RST_ZERO;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `FTIC_A_EN:     en     <= reg_wdata;
                    `FTIC_A_CFG1:   cfg1   <= reg_wdata;
                    `FTIC_A_CFG2:   cfg2   <= reg_wdata;
                    `FTIC_A_DUR:    dur    <= reg_wdata;
                    `FTIC_A_VINMON: vinmon <= reg_wdata;
                    `FTIC_A_TORCH:  torch  <= reg_wdata;
                    `FTIC_A_FLASH:  flash  <= reg_wdata;
                    `FTIC_A_IND:    ind    <= reg_wdata;
                    `FTIC_A_BLINK:  blnk   <= reg_wdata;
                    default:        ;
                endcase
            end
            // a register flash ends itself after the timeout
            if (to_hit && en[`FTIC_EN_MODE_HI:`FTIC_EN_MODE_LO] == `FTIC_MODE_FLASH)
                en[`FTIC_EN_MODE_HI:`FTIC_EN_MODE_LO] <= 2'h0;
            if (flash_end && cfg1[`FTIC_C1_HWT])
                cfg1[`FTIC_C1_HWT] <= 1'b0;
        end
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `FTIC_A_EN:     reg_rdata <= en;
                `FTIC_A_CFG1:   reg_rdata <= cfg1;
                `FTIC_A_CFG2:   reg_rdata <= cfg2;
                `FTIC_A_DUR:    reg_rdata <= dur;
                `FTIC_A_VINMON: reg_rdata <= vinmon;
                `FTIC_A_TORCH:  reg_rdata <= torch;
                `FTIC_A_FLASH:  reg_rdata <= flash;
                `FTIC_A_IND:    reg_rdata <= ind;
                `FTIC_A_BLINK:  reg_rdata <= blnk;
                `FTIC_A_FLAGS:  reg_rdata <= flags;
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    // sync pin: active level follows the polarity bit
    // sync polarity
    assign sync_act  = !cfg1[`FTIC_C1_HWT] && (pa_sync_torch_pin == cfg1[`FTIC_C1_POL]);
    assign sync_edge = sync_act && !sync_prev;

    // edge-triggered shutdown, re-armed by a flags read; a new edge wins
    // sync shutdown
    always_ff @(posedge core_clk)
    begin
        sync_prev <= !srst && sync_act;
        if (srst || !hardware_shutdown_pin)
        begin
            sync_shut  <= 1'b0;
            sync_armed <= 1'b1;
        end
        else if (cfg2[`FTIC_C2_SYNCSD] && sync_edge && sync_armed)
        begin
            sync_shut  <= 1'b1;
            sync_armed <= 1'b0;
        end
        else if (flags_rd)
        begin
            sync_shut  <= 1'b0;
            sync_armed <= 1'b1;
        end
    end

    // input monitor deglitch: must stay low for the whole window
    // monitor enable
    assign vin_trip = vinmon[0] && uv_s && degl_cnt == DGW'(DEGL_CYCLES - 1);
    always_ff @(posedge core_clk)
    begin
        if (srst || !vinmon[0] || !uv_s)
            degl_cnt <= '0;
        else if (degl_cnt != DGW'(DEGL_CYCLES - 1))
            degl_cnt <= degl_cnt + DGW'(1);
    end

    // event holds until recovery and a flags read
    // monitor release
    always_ff @(posedge core_clk)
    begin
        if (srst || !hardware_shutdown_pin)
            vin_evt <= 1'b0;
        else if (vin_trip)
            vin_evt <= 1'b1;
        else if (flags_rd && !uv_s)
            vin_evt <= 1'b0;
    end

    // flash timeout counted in ms ticks while a flash is requested
    // flash timeout
    assign raw_flash = en[`FTIC_EN_MODE_HI:`FTIC_EN_MODE_LO] == `FTIC_MODE_FLASH
                       || (en[`FTIC_EN_STRB] && strobe_pin);
    assign flash_req = raw_flash && !to_done;
    assign to_lim    = {1'b0, dur[4:0], 5'h00} + 11'd32;
    assign to_hit    = flash_req && to_ms == to_lim;
    assign flash_end = flash_prev && !flash_req;
    always_ff @(posedge core_clk)
    begin
        flash_prev <= !srst && flash_req;
        if (srst || !flash_req)
            to_ms <= 11'h000;
        else if (ms_tick)
            to_ms <= to_ms + 11'h001;
        if (srst || !raw_flash)
            to_done <= 1'b0;
        else if (to_hit)
            to_done <= 1'b1;
    end

    // mode choice
    // flash priority
    always_comb
    begin
        force_off   = !hardware_shutdown_pin || sync_shut
                      || (vin_evt && cfg2[`FTIC_C2_VINSD])
                      || !(en[`FTIC_EN_SRCA] || en[`FTIC_EN_SRCB]);
        force_torch = (sync_act && !sync_shut) || (vin_evt && !cfg2[`FTIC_C2_VINSD]);
        torch_req   = en[`FTIC_EN_MODE_HI:`FTIC_EN_MODE_LO] == `FTIC_MODE_TORCH
                      || (cfg1[`FTIC_C1_HWT] && pa_sync_torch_pin);
        if (force_off)
            next_mode = FTIC_OFF;
        else if (flash_req)
            next_mode = force_torch ? FTIC_TORCH : FTIC_FLASH;
        else if (torch_req && !flash_end)
            next_mode = FTIC_TORCH;
        else
            next_mode = FTIC_OFF;
    end

    // source outputs and their current codes
    // source enables
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mode          <= FTIC_OFF;
            source_a_on   <= 1'b0;
            source_b_on   <= 1'b0;
            source_a_code <= 4'h0;
            source_b_code <= 4'h0;
        end
        else
        begin
            mode          <= next_mode;
            source_a_on   <= next_mode != FTIC_OFF && en[`FTIC_EN_SRCA];
            source_b_on   <= next_mode != FTIC_OFF && en[`FTIC_EN_SRCB];
            source_a_code <= next_mode == FTIC_FLASH ? flash[3:0] : torch[3:0];
            source_b_code <= next_mode == FTIC_FLASH ? flash[7:4] : torch[7:4];
        end
    end
    assign flash_mode = mode == FTIC_FLASH;

    // switch gating; limit trip holds to the next cycle start
    // current limit
    always_ff @(posedge core_clk)
    begin
        if (srst)
            ilim_hold <= 1'b0;
        else if (ilim_s)
            ilim_hold <= 1'b1;
        else if (sw_cycle_start)
            ilim_hold <= 1'b0;
    end
    assign power_sw_en             = mode != FTIC_OFF && !ovp_s && !ilim_hold;
    assign ilim_sel                = dur[6:5];
    assign input_monitor_en        = vinmon[0];
    assign input_monitor_threshold = vinmon[2:1];

    // sticky flags; a new event in the read cycle survives the clear
    // flags clear on read
    always_comb
    begin
        flag_set               = 8'h00;
        flag_set[`FTIC_FL_TO]   = to_hit;
        flag_set[`FTIC_FL_OVP]  = ovp_s && !ovp_prev;
        flag_set[`FTIC_FL_VIN]  = vin_trip && !vin_evt;
        flag_set[`FTIC_FL_SYNC] = sync_edge;
    end
    always_ff @(posedge core_clk)
    begin
        ovp_prev <= !srst && ovp_s;
        if (srst || !hardware_shutdown_pin)
            flags <= 8'h00;
        else
            flags <= (flags & ~{8{flags_rd}}) | flag_set;
    end

    // indicator pin function and pattern
    // pin function
    assign thermistor_sel    = cfg1[`FTIC_C1_NTC];
    assign indicator_current = ind[2:0];
    assign indicator_on      = ind_lit;
    ftic_blink u_blink (
        .core_clk (core_clk),
        .srst     (srst),
        .ms_tick  (ms_tick),
        .enable   (en[`FTIC_EN_IND] && !cfg1[`FTIC_C1_NTC]),
        .blink    (en[`FTIC_EN_BLINK]),
        .period_n (ind[5:3]),
        .ramp_sel (ind[7:6]),
        .pulse_sel(blnk[3:0]),
        .blank_n  (blnk[7:4]),
        .phase    (indicator_phase),
        .lit      (ind_lit)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence sync_hit_s;
        cfg2[`FTIC_C2_SYNCSD] && sync_edge && sync_armed;
    endsequence
    sync_shutdown_a: assert property (sync_hit_s |=> sync_shut ##1 mode == FTIC_OFF)
        else $error("sync edge did not shut down");
    flash_prio_a: assert property (flash_req && !force_off && !force_torch
                                   |=> flash_mode)
        else $error("flash lost priority");
    src_enable_a: assert property (source_a_on |-> $past(en[`FTIC_EN_SRCA]))
        else $error("source a on while disabled");
    timeout_flag_a: assert property (to_hit && !flags_rd |=> flags[`FTIC_FL_TO] && !flash_req)
        else $error("timeout not flagged");
    hw_torch_clr_a: assert property (flash_end && cfg1[`FTIC_C1_HWT] && hardware_shutdown_pin
                                     |=> !cfg1[`FTIC_C1_HWT])
        else $error("torch bit not cleared");
    vin_hold_a: assert property (vin_evt && uv_s |=> vin_evt)
        else $error("monitor released early");
    vin_degl_a: assert property (!uv_s |=> !$rose(vin_evt))
        else $error("monitor acted without deglitch");
    flags_rd_a: assert property (flags_rd && flag_set == 8'h00 && hardware_shutdown_pin
                                 |=> flags == 8'h00)
        else $error("flags not cleared by read");
    ovp_stop_a: assert property (ovp_s |-> !power_sw_en)
        else $error("switching during overvoltage");

endmodule

/* hdl/ftic_pkg.sv */
/*
 types of the flash, torch and indicator control block.
 assumes nothing of its surroundings.
*/
package ftic_pkg;

    // led source operating state
    typedef enum logic [2:0] {
        FTIC_OFF   = 3'b001,
        FTIC_TORCH = 3'b010,
        FTIC_FLASH = 3'b100
    } ftic_mode_e;

    // indicator pattern phase
    typedef enum logic [4:0] {
        FTIC_IDLE = 5'b00001,
        FTIC_RISE = 5'b00010,
        FTIC_HOLD = 5'b00100,
        FTIC_FALL = 5'b01000,
        FTIC_LOW  = 5'b10000
    } ftic_phase_e;

endpackage

/* testbench/ftic_host.sv */
/*
 host side of the register port: single byte writes and reads.
 assumes it is the only driver of the register port, fed at falling edges.
*/
`timescale 1ns/100ps
`include "ftic_consts.svh"

module ftic_host
(
    // clock
    input  wire logic        core_clk,
    // register port
    output logic      [7:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // after a write the idle bus shows the inverse address and data; a read inverts only the address
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one strobe cycle, then a free cycle before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask

    task automatic ind_pattern(input logic [7:0] ind, input logic [7:0] blk);
        wr(`FTIC_A_EN, 8'h00);
        wr(`FTIC_A_IND, ind);
        wr(`FTIC_A_BLINK, blk);
        wr(`FTIC_A_EN, 8'h40);
    endtask
endmodule

/* testbench/tb_top.sv */
/*
 self-checking bench of the flash, torch and indicator control core.
 assumes short millisecond and deglitch parameters; comparators driven here.
*/
`timescale 1ns/100ps
`include "ftic_consts.svh"

module tb_top
    import ftic_pkg::*;
;
    typedef struct {string nm; logic [7:0] v;} ftic_note_s;
    ftic_note_s  notes[$];
    ftic_note_s  nt;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hw_en = 1'b1;
    logic        pa_sync = 1'b0;
    logic        ovp = 1'b0;
    logic        vin = 1'b0;
    logic        rd_pend = 1'b0;
    logic        obs_go = 1'b0;
    logic [7:0]  obs_v = 8'h00;
    logic [7:0]  got;
    logic [7:0]  tv;
    logic [7:0]  fv;
    int          n_errors = 0;
    int          checks_done = 0;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, source_a_on, source_b_on, flash_mode;
    wire         power_sw_en, thermistor_sel, indicator_on;
    wire  [3:0]  source_a_code, source_b_code;
    wire  [1:0]  ilim_sel;
    wire  [2:0]  indicator_current;
    wire  [4:0]  ind_phase;
    wire  [7:0]  a_view = {source_a_on, source_b_on, flash_mode, 1'b0, source_a_code};

    // 200 mhz clock
    always #2.5 core_clk = ~core_clk;

    ftic_host i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    // short counts keep the timeout near 640 cycles
    ftic_core #(.MS_CYCLES(20), .DEGL_CYCLES(10)) i_ftic_core (.core_clk(core_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hardware_shutdown_pin(hw_en),
        .strobe_pin(1'b0), .pa_sync_torch_pin(pa_sync), .vin_below_cmp(vin),
        .ovp_cmp(ovp), .ilim_cmp(1'b0), .sw_cycle_start(1'b0),
        .source_a_on(source_a_on), .source_b_on(source_b_on),
        .source_a_code(source_a_code), .source_b_code(source_b_code),
        .flash_mode(flash_mode), .power_sw_en(power_sw_en), .ilim_sel(ilim_sel),
        .input_monitor_en(), .input_monitor_threshold(), .thermistor_sel(thermistor_sel),
        .indicator_on(indicator_on), .indicator_current(indicator_current),
        .indicator_phase(ind_phase));

    // watcher: read data lands one cycle after the strobe, views on obs_go
    always @(posedge core_clk)
    begin
        rd_pend <= reg_rd;
        if (rd_pend || obs_go)
        begin
            nt = notes.pop_front();
            got = rd_pend ? reg_rdata : obs_v;
            checks_done++;
            if (got !== nt.v)
            begin
                n_errors++;
                $display("wrong value %s expected %h seen %h", nt.nm, nt.v, got);
            end
        end
    end

    task automatic rdx(input logic [7:0] a, input logic [7:0] e, input string nm);
        notes.push_back('{nm, e});
        i_host.rd(a);
        @(negedge core_clk);
    endtask

    task automatic look(input string nm, input logic [7:0] e, input logic [7:0] v);
        notes.push_back('{nm, e});
        obs_v = v;
        obs_go = 1'b1;
        @(negedge core_clk);
        obs_go = 1'b0;
    endtask

    task automatic conclude();
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog: the tests need about 1500 cycles
    initial
    begin
        #50000;
        n_errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(76997));
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        srst = 1'b0;
        rdx(`FTIC_A_CFG1, `FTIC_RST_CFG1, "cfg1 reset");
        rdx(`FTIC_A_EN, `FTIC_RST_ZERO, "enable reset");
        rdx(8'h55, 8'h00, "unmapped");
        i_host.ind_pattern(8'h05, 8'h00);
        // the sequencer leaves idle one edge after the enable lands
        @(negedge core_clk);
        look("indicator", 8'h0d, {3'h0, thermistor_sel, indicator_on, indicator_current});
        i_host.wr(`FTIC_A_EN, 8'h00);
        i_host.wr(`FTIC_A_EN, 8'hc0);
        @(negedge core_clk);
        look("blink rise", 8'h22, {2'h0, indicator_on, ind_phase});
        tv = $urandom;
        fv = $urandom;
        i_host.wr(`FTIC_A_TORCH, tv);
        i_host.wr(`FTIC_A_FLASH, fv);
        i_host.wr(`FTIC_A_DUR, 8'h40);
        rdx(`FTIC_A_TORCH, tv, "torch reg");
        look("ilim", 8'h02, {6'h00, ilim_sel});
        i_host.wr(`FTIC_A_EN, 8'h1a);
        repeat (3) @(negedge core_clk);
        look("torch a", {4'hc, tv[3:0]}, a_view);
        look("torch b", {4'h0, tv[7:4]}, {4'h0, source_b_code});
        // overvoltage stops switching after the two sync stages
        ovp = 1'b1;
        repeat (3) @(negedge core_clk);
        look("switch", 8'h00, {7'h00, power_sw_en});
        ovp = 1'b0;
        rdx(`FTIC_A_FLAGS, 8'h04, "ovp flag");
        // flash on source a only, then the 32 ms timeout
        i_host.wr(`FTIC_A_EN, 8'h13);
        repeat (3) @(negedge core_clk);
        look("flash a", {4'ha, fv[3:0]}, a_view);
        repeat (580) @(negedge core_clk);
        look("flash held", 8'h01, {7'h00, flash_mode});
        repeat (100) @(negedge core_clk);
        look("flash end", 8'h00, {7'h00, flash_mode});
        rdx(`FTIC_A_FLAGS, 8'h01, "timeout flag");
        rdx(`FTIC_A_FLAGS, 8'h00, "flags cleared");
        rdx(`FTIC_A_EN, 8'h10, "enable after");
        // pin torch, then a register flash that overrides it
        i_host.wr(`FTIC_A_CFG1, 8'ha0);
        i_host.wr(`FTIC_A_EN, 8'h18);
        pa_sync = 1'b1;
        repeat (3) @(negedge core_clk);
        look("pin torch", {4'hc, tv[3:0]}, a_view);
        i_host.wr(`FTIC_A_EN, 8'h1b);
        repeat (3) @(negedge core_clk);
        look("flash wins", {4'he, fv[3:0]}, a_view);
        repeat (700) @(negedge core_clk);
        pa_sync = 1'b0;
        look("pin torch off", 8'h00, {6'h00, source_a_on, source_b_on});
        rdx(`FTIC_A_CFG1, 8'h20, "cfg1 cleared");
        // monitor shutdown only after the deglitch window; the timeout and
        // the sync edge seen when config1 bit 7 cleared with the pin high are still flagged
        i_host.wr(`FTIC_A_CFG2, 8'h18);
        i_host.wr(`FTIC_A_VINMON, 8'h01);
        i_host.wr(`FTIC_A_EN, 8'h1b);
        vin = 1'b1;
        repeat (4) @(negedge core_clk);
        look("vin deglitch", 8'h03, {6'h00, source_a_on, source_b_on});
        repeat (12) @(negedge core_clk);
        look("vin shutdown", 8'h00, {6'h00, source_a_on, source_b_on});
        vin = 1'b0;
        repeat (3) @(negedge core_clk);
        rdx(`FTIC_A_FLAGS, 8'h51, "vin flag");
        look("vin release", 8'h03, {6'h00, source_a_on, source_b_on});
        // sync edge shuts down; a flags read with the pin held gives torch
        pa_sync = 1'b1;
        repeat (4) @(negedge core_clk);
        look("sync shutdown", 8'h00, {6'h00, source_a_on, source_b_on});
        rdx(`FTIC_A_FLAGS, 8'h40, "sync flag");
        repeat (2) @(negedge core_clk);
        look("sync torch", {4'hc, tv[3:0]}, a_view);
        pa_sync = 1'b0;
        repeat (3) @(negedge core_clk);
        conclude();
    end
endmodule
